// File: logic/rht_top.sv
// Purpose: Bus target of a humidity/temperature sensor
// Assumes: Bus pins are asynchronous and oversampled by clk
// Notes:   Open-drain data pin, only ever pulled low
`timescale 1ns/1ps
`include "rht_defs.svh"
module rht_top #(
  parameter int       TICK_CYC     = `RHT_TICK_US*`RHT_CLK_MHZ,
  parameter bit       SOFT_ADDR_EN = 1'b0,
  parameter bit [6:0] SOFT_ADDR    = 7'h00 // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Bus pins
  input  wire logic        scl_pin,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Strap and reset pins
  input  wire logic        address_strap_pin,
  input  wire logic        rst_pin_n,
  // Sensor front end
  input  wire logic [15:0] raw_hum,
  input  wire logic [15:0] raw_tmp,
  // Status
  output logic             heater_en,
  output logic             ready,
  output logic             meas_busy
);
  import rht_pkg::*;
  rht_conv_if cv ();
  logic [1:0]  scl_s;
  logic [1:0]  sda_s;
  logic [1:0]  rst_s;
  logic [1:0]  strap_s;
  logic        scl_d;
  logic        sda_d;
  logic        bus_start;
  logic        bus_stop;
  logic        scl_rise;
  logic        scl_fall;
  logic        quiet;
  logic        srst;
  logic        addr_hit;
  logic [7:0]  rcnt;
  logic [7:0]  next_rcnt;
  rht_tick_t   init;
  rht_tick_t   next_init;
  logic        next_ready;
  rht_state_e  state;
  rht_state_e  next_state;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic [7:0]  sh;
  logic [7:0]  next_sh;
  logic [47:0] tx;
  logic [47:0] next_tx;
  logic [2:0]  txleft;
  logic [2:0]  next_left;
  logic        rw;
  logic        next_rw;
  logic        rd_rh;
  logic        next_rd_rh;
  logic        strap;
  logic        next_strap;
  logic        rst_pend;
  logic        next_pend;
  logic        cmd_rst;
  logic        next_cmd_rst;
  logic        start;
  logic        next_start;
  rht_osr_t    osr_h;
  rht_osr_t    next_osr_h;
  rht_osr_t    osr_t;
  rht_osr_t    next_osr_t;
  logic [15:0] hum;
  logic [15:0] next_hum;
  logic [15:0] tmp;
  logic [15:0] next_tmp;
  logic        next_oe;
  logic        next_heat;

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = `RHT_CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ `RHT_CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus events, no timeout anywhere
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_s   <= 2'h3;
      sda_s   <= 2'h3;
      rst_s   <= 2'h3;
      strap_s <= 2'h0;
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
    end
    else
    begin
      scl_s   <= {scl_s[0], scl_pin};
      sda_s   <= {sda_s[0], sda_in};
      rst_s   <= {rst_s[0], rst_pin_n};
      strap_s <= {strap_s[0], address_strap_pin};
      scl_d   <= scl_s[1];
      sda_d   <= sda_s[1];
    end
  end

  assign bus_start = scl_s[1] && scl_d && sda_d && !sda_s[1];
  assign bus_stop  = scl_s[1] && scl_d && !sda_d && sda_s[1];
  assign scl_rise  = scl_s[1] && !scl_d;
  assign scl_fall  = !scl_s[1] && scl_d;
  assign quiet     = !srst && !bus_start && !bus_stop;
  assign addr_hit  = (sh[6:0] == {`RHT_ADDR_HI, strap})
                  || (SOFT_ADDR_EN && sh[6:0] == SOFT_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // Reset pin filter and start-up timer
  assign srst = (rcnt == 8'(`RHT_RST_MIN_CYC)) || cmd_rst;

  always_comb
  begin
    next_rcnt = rcnt;
    if (rst_s[1])
      next_rcnt = 8'h0;
    else if (rcnt != 8'(`RHT_RST_MIN_CYC))
      next_rcnt = rcnt + 8'h1;
    next_init = init;
    if (srst)
      next_init = cmd_rst ? `RHT_SRST_10US : `RHT_PWRUP_10US;
    else if (init != 12'h0 && cv.tick)
      next_init = init - 12'h1;
    next_ready = (init == 12'h0) && !srst;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rcnt  <= 8'h0;
      init  <= `RHT_PWRUP_10US;
      ready <= 1'b0;
    end
    else
    begin
      rcnt  <= next_rcnt;
      init  <= next_init;
      ready <= next_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus target
  always_comb
  begin
    next_state   = state;
    next_cnt     = cnt;
    next_sh      = sh;
    next_tx      = tx;
    next_left    = txleft;
    next_rw      = rw;
    next_rd_rh   = rd_rh;
    next_strap   = strap;
    next_pend    = rst_pend;
    next_cmd_rst = 1'b0;
    next_start   = 1'b0;
    next_osr_h   = osr_h;
    next_osr_t   = osr_t;
    next_hum     = hum;
    next_tmp     = tmp;
    next_oe      = sda_oe;
    next_heat    = heater_en;
    if (cv.done)
    begin
      next_hum = raw_hum;
      next_tmp = raw_tmp;
    end
    if (srst)
    begin
      next_state = ST_IDLE;
      next_oe    = 1'b0;
      next_heat  = 1'b0;
      next_pend  = 1'b0;
      next_rd_rh = 1'b0;
    end
    else if (bus_start)
    begin
      next_state = ST_ADDR;
      next_cnt   = 3'h0;
      next_oe    = 1'b0;
      next_strap = strap_s[1];
    end
    else if (bus_stop)
    begin
      next_state   = ST_IDLE;
      next_oe      = 1'b0;
      next_cmd_rst = rst_pend;
      next_pend    = 1'b0;
    end
    else
      case (state)
        ST_ADDR, ST_CMD:
          if (scl_rise)
          begin
            next_sh  = {sh[6:0], sda_s[1]};
            next_cnt = cnt + 3'h1;
            if (cnt == 3'h7 && state == ST_ADDR)
            begin
              next_state = (addr_hit && ready) ? ST_AACK : ST_WAIT;
              next_rw    = sda_s[1];
              next_tx    = rd_rh ? {hum, crc8(hum), 24'h0}
                                 : {tmp, crc8(tmp), hum, crc8(hum)};
              next_left  = rd_rh ? `RHT_TX_RH : `RHT_TX_TRH;
            end
            else if (cnt == 3'h7)
            begin
              next_state = ST_CACK;
              if (sh[6:4] == `RHT_CMD_CONV)
              begin
                next_start = 1'b1;
                next_osr_h = sh[3:2];
                next_osr_t = sh[1:0];
              end
              else
                case (sh[6:0])
                  `RHT_CMD_HEAT_ON:  next_heat  = 1'b1;
                  `RHT_CMD_HEAT_OFF: next_heat  = 1'b0;
                  `RHT_CMD_RD_TRH:   next_rd_rh = 1'b0;
                  `RHT_CMD_RD_RH:    next_rd_rh = 1'b1;
                  `RHT_CMD_RESET:    next_pend  = 1'b1;
                  default:           next_pend  = rst_pend;
                endcase
            end
          end
        ST_AACK, ST_CACK:
          if (scl_fall)
          begin
            next_cnt = 3'h0;
            if (!sda_oe)
              next_oe = 1'b1;
            else if (state == ST_AACK && rw)
            begin
              next_oe    = ~tx[47];
              next_state = ST_TX;
            end
            else
            begin
              next_oe    = 1'b0;
              next_state = (state == ST_AACK) ? ST_CMD : ST_WAIT;
            end
          end
        ST_TX:
        begin
          if (scl_fall)
          begin
            next_tx = {tx[46:0], 1'b0};
            next_oe = ~tx[46];
          end
          if (scl_rise)
          begin
            next_cnt = cnt + 3'h1;
            if (cnt == 3'h7)
              next_state = ST_TXR;
          end
        end
        ST_TXR:
          if (scl_fall)
          begin
            next_oe    = 1'b0;
            next_tx    = {tx[46:0], 1'b0};
            next_left  = txleft - 3'h1;
            next_state = ST_MACK;
          end
        ST_MACK:
          if (scl_rise)
            next_state = (!sda_s[1] && txleft != 3'h0) ? ST_TXN : ST_WAIT;
        ST_TXN:
          if (scl_fall)
          begin
            next_oe    = ~tx[47];
            next_cnt   = 3'h0;
            next_state = ST_TX;
          end
        default: next_state = state;
      endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state     <= ST_IDLE;
      cnt       <= 3'h0;
      sh        <= 8'h0;
      tx        <= 48'h0;
      txleft    <= 3'h0;
      rw        <= 1'b0;
      rd_rh     <= 1'b0;
      strap     <= 1'b0;
      rst_pend  <= 1'b0;
      cmd_rst   <= 1'b0;
      start     <= 1'b0;
      osr_h     <= 2'h0;
      osr_t     <= 2'h0;
      hum       <= 16'h0;
      tmp       <= 16'h0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
      heater_en <= 1'b0;
      meas_busy <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      sh        <= next_sh;
      tx        <= next_tx;
      txleft    <= next_left;
      rw        <= next_rw;
      rd_rh     <= next_rd_rh;
      strap     <= next_strap;
      rst_pend  <= next_pend;
      cmd_rst   <= next_cmd_rst;
      start     <= next_start;
      osr_h     <= next_osr_h;
      osr_t     <= next_osr_t;
      hum       <= next_hum;
      tmp       <= next_tmp;
      sda_oe    <= next_oe;
      sda_out   <= 1'b0;
      heater_en <= next_heat;
      meas_busy <= cv.busy;
    end
  end

  assign cv.start = start;
  assign cv.clr   = srst;
  assign cv.osr_h = osr_h;
  assign cv.osr_t = osr_t;

  rht_conv #(.TICK_CYC(TICK_CYC)) u_conv (
    .clk  (clk),
    .nrst (nrst),
    .cv   (cv)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_no_timeout: assert property (
    state != ST_IDLE && quiet && !scl_rise && !scl_fall
    |=> state == $past(state))
    else $error("state moved without bus activity");
  a_bit_held: assert property (
    state == ST_TX && quiet && !scl_fall |=> $stable(sda_oe))
    else $error("read bit changed before falling clock");
  a_bit_placed: assert property (
    state == ST_TX && quiet && scl_fall |=> sda_oe == !$past(tx[46]))
    else $error("read bit not placed after falling clock");
  a_strap_addr: assert property (
    state == ST_ADDR && quiet && scl_rise && cnt == 3'h7 && ready
    && sh[6:0] == {`RHT_ADDR_HI, strap} |=> state == ST_AACK)
    else $error("strap address not acknowledged");
  a_other_addr: assert property (
    state == ST_ADDR && quiet && scl_rise && cnt == 3'h7 && !SOFT_ADDR_EN
    && sh[6:0] != {`RHT_ADDR_HI, strap} |=> state == ST_WAIT)
    else $error("foreign address acknowledged");
  a_rst_pulse: assert property (
    rcnt == 8'(`RHT_RST_MIN_CYC - 1) && !rst_s[1]
    |=> srst ##1 !ready && state == ST_IDLE)
    else $error("reset pulse did not reset");
  a_conv_fields: assert property (
    state == ST_CMD && quiet && scl_rise && cnt == 3'h7
    && sh[6:4] == `RHT_CMD_CONV
    |=> start && osr_h == $past(sh[3:2]) && osr_t == $past(sh[1:0]))
    else $error("conversion fields not taken");
  a_meas_store: assert property (
    cv.done |=> hum == $past(raw_hum) && tmp == $past(raw_tmp))
    else $error("results not stored at conversion end");
  a_no_ack_init: assert property (
    !ready |-> state != ST_AACK && state != ST_CACK || !quiet)
    else $error("acknowledge before initialisation");

  c_read_trh: cover property (state == ST_MACK && txleft == 3'h0);
  c_conv_cmd: cover property (start);
  c_soft_rst: cover property (cmd_rst);
endmodule

// File: logic/rht_defs.svh
// Purpose: Shared constants of the humidity/temperature bus target
// Assumes: 200 MHz core clock
// Notes:   Times in 10 us ticks unless named otherwise
`ifndef RHT_DEFS_SVH
`define RHT_DEFS_SVH
// Clock and time base
`define RHT_CLK_MHZ       200
`define RHT_TICK_US       10
// Reset pin: least low time in ns and cycles
`define RHT_RST_MIN_NS    1000
`define RHT_RST_MIN_CYC   ((`RHT_RST_MIN_NS*`RHT_CLK_MHZ+999)/1000)
`define RHT_RST_W         8
// Start-up times in ticks: power up 10 ms, soft reset 15 ms
`define RHT_PWRUP_10US    12'd1000
`define RHT_SRST_10US     12'd1500
// Humidity conversion, osr 3..0: 8.34/4.21/2.14/1.11 ms
`define RHT_HUM3_10US     12'd834
`define RHT_HUM2_10US     12'd421
`define RHT_HUM1_10US     12'd214
`define RHT_HUM0_10US     12'd111
// Temperature conversion, osr 3..0: 11.98/6.03/3.06/1.57 ms
`define RHT_TMP3_10US     12'd1198
`define RHT_TMP2_10US     12'd603
`define RHT_TMP1_10US     12'd306
`define RHT_TMP0_10US     12'd157
// Target address: upper six bits, strap gives the lsb
`define RHT_ADDR_HI       6'h20
// Command byte, bits 7:5 or 7:1
`define RHT_CMD_CONV      3'h2
`define RHT_CMD_RESET     7'h0f
`define RHT_CMD_HEAT_ON   7'h02
`define RHT_CMD_HEAT_OFF  7'h01
`define RHT_CMD_RD_TRH    7'h00
`define RHT_CMD_RD_RH     7'h08
// Read framing
`define RHT_TX_TRH        3'h6
`define RHT_TX_RH         3'h3
`define RHT_CRC_POLY      8'h31
`define RHT_CRC_INIT      8'h00
`endif

// File: logic/rht_pkg.sv
// Purpose: Types of the humidity/temperature bus target
// Assumes: Nothing
// Notes:   Constants live in rht_defs.svh
package rht_pkg;
  typedef logic [1:0] rht_osr_t;
  typedef logic [11:0] rht_tick_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h2,
    ST_CMD  = 4'h3,
    ST_CACK = 4'h4,
    ST_TX   = 4'h5,
    ST_TXR  = 4'h6,
    ST_MACK = 4'h7,
    ST_TXN  = 4'h8,
    ST_WAIT = 4'h9
  } rht_state_e;
endpackage

// File: logic/rht_conv_if.sv
// Purpose: Link between bus target and conversion timer
// Assumes: Single clock domain
// Notes:   tick is the shared 10 us enable
`timescale 1ns/1ps
interface rht_conv_if;
  import rht_pkg::*;
  logic     start;
  logic     clr;
  rht_osr_t osr_h;
  rht_osr_t osr_t;
  logic     tick;
  logic     busy;
  logic     done;
  modport ctl (output start, clr, osr_h, osr_t, input tick, busy, done);
  modport tmr (input start, clr, osr_h, osr_t, output tick, busy, done);
endinterface

// File: logic/rht_conv.sv
// Purpose: Tick divider and conversion duration timer
// Assumes: start is a one-cycle pulse
// Notes:   Humidity then temperature, total time of both
`timescale 1ns/1ps
`include "rht_defs.svh"
module rht_conv #(
  parameter int TICK_CYC = `RHT_TICK_US*`RHT_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  rht_conv_if.tmr  cv
);
  import rht_pkg::*;
  logic [15:0] div;
  logic [15:0] next_div;
  logic        tick;
  logic        next_tick;
  rht_tick_t   left;
  rht_tick_t   next_left;
  logic        busy;
  logic        next_busy;
  logic        done;
  logic        next_done;
  rht_tick_t   hum_t;
  rht_tick_t   tmp_t;

  ////////////////////////////////////////////////////////////////////////
  // Duration lookup
  always_comb
  begin
    case (cv.osr_h)
      2'h3:    hum_t = `RHT_HUM3_10US;
      2'h2:    hum_t = `RHT_HUM2_10US;
      2'h1:    hum_t = `RHT_HUM1_10US;
      default: hum_t = `RHT_HUM0_10US;
    endcase
    case (cv.osr_t)
      2'h3:    tmp_t = `RHT_TMP3_10US;
      2'h2:    tmp_t = `RHT_TMP2_10US;
      2'h1:    tmp_t = `RHT_TMP1_10US;
      default: tmp_t = `RHT_TMP0_10US;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider and timer
  always_comb
  begin
    next_tick = (div == 16'(TICK_CYC - 1));
    next_div  = next_tick ? 16'h0 : div + 16'h1;
    next_left = left;
    next_busy = busy;
    next_done = 1'b0;
    if (cv.clr)
    begin
      next_left = '0;
      next_busy = 1'b0;
    end
    else if (cv.start)
    begin
      next_left = hum_t + tmp_t;
      next_busy = 1'b1;
      next_div  = 16'h0;
      next_tick = 1'b0;
    end
    else if (busy && tick)
    begin
      next_left = left - 12'h1;
      if (left == 12'h1)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div  <= 16'h0;
      tick <= 1'b0;
      left <= 12'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      div  <= next_div;
      tick <= next_tick;
      left <= next_left;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign cv.tick = tick;
  assign cv.busy = busy;
  assign cv.done = done;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_hum_osr3_len: assert property (
    cv.start && !cv.clr && cv.osr_h == 2'h3 && cv.osr_t == 2'h0
    |=> busy && left == `RHT_HUM3_10US + `RHT_TMP0_10US)
    else $error("humidity osr3 duration wrong");
  a_tmp_osr3_len: assert property (
    cv.start && !cv.clr && cv.osr_h == 2'h0 && cv.osr_t == 2'h3
    |=> busy && left == `RHT_HUM0_10US + `RHT_TMP3_10US)
    else $error("temperature osr3 duration wrong");
  c_conv_done: cover property (busy ##1 done);
endmodule

// File: sim/rht_host.sv
// Purpose: Bus controller model for the sensor's clock and data pins
// Assumes: Data line has a pull-up; this model only ever pulls it low
// Notes:   Clock stands high between frames; half_ns sets its speed
`timescale 1ns/1ps
module rht_host (
  // Bus pins
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  real half_ns  = 62.5;
  int  unstable = 0;

  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit level: data moves only mid-low, sampled just before the fall
  task automatic bit_out(input logic b);
    #(half_ns / 2) sda_pull = ~b;
    #(half_ns / 2) scl = 1'b1;
    #(half_ns) scl = 1'b0;
  endtask

  task automatic bit_in(output logic b);
    logic first;
    #(half_ns / 2) sda_pull = 1'b0;
    #(half_ns / 2) scl = 1'b1;
    first = sda;
    #(half_ns - 1.0) b = sda;
    if (b !== first)
      unstable++;
    #1.0 scl = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Frame level
  task automatic bus_start();
    #(half_ns / 2) sda_pull = 1'b0;
    #(half_ns / 2) scl = 1'b1;
    #(half_ns) sda_pull = 1'b1;
    #(half_ns) scl = 1'b0;
  endtask

  task automatic bus_stop();
    #(half_ns / 2) sda_pull = 1'b1;
    #(half_ns / 2) scl = 1'b1;
    #(half_ns) sda_pull = 1'b0;
    #(half_ns);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask

  // Last byte answered with a release (no acknowledge)
  task automatic rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(last);
  endtask
endmodule

// File: sim/rht_top_tb.sv
// Purpose: Self-checking bench of the sensor bus target
// Assumes: Tick shortened to 4 cycles; bus clock period 125 ns, 2000 ns for the slow read
// Notes:   Scenarios run in order; each judges its own results
`timescale 1ns/1ps
`include "rht_defs.svh"
module rht_top_tb;
  localparam int          TICK  = 4;
  localparam int          PWR   = 1000 * TICK;
  localparam int          SRST  = 1500 * TICK;
  localparam logic [15:0] HUM_A = 16'h8c3a;
  localparam logic [15:0] TMP_A = 16'h61f5;

  logic        clk;
  logic        nrst;
  logic        scl;
  logic        sda_pull;
  wire logic   sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic        strap;
  logic        rst_pin_n;
  logic [15:0] raw_hum;
  logic [15:0] raw_tmp;
  logic        heater_en;
  logic        ready;
  logic        meas_busy;
  int          num_errors = 0;
  int          checks     = 0;
  int          cyc        = 0;
  int          t_rise     = 0;
  int          t_fall     = 0;
  int          t_ready    = 0;

  // Open-drain data line with pull-up
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

  rht_top #(.TICK_CYC(TICK)) u_rht_top (
    .clk               (clk),
    .nrst              (nrst),
    .scl_pin           (scl),
    .sda_in            (sda_line),
    .sda_out           (sda_out),
    .sda_oe            (sda_oe),
    .address_strap_pin (strap),
    .rst_pin_n         (rst_pin_n),
    .raw_hum           (raw_hum),
    .raw_tmp           (raw_tmp),
    .heater_en         (heater_en),
    .ready             (ready),
    .meas_busy         (meas_busy)
  );

  rht_host u_rht_host (.scl(scl), .sda_pull(sda_pull), .sda(sda_line));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge meas_busy) t_rise = cyc;
  always @(negedge meas_busy) t_fall = cyc;
  always @(posedge ready) t_ready = cyc;

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string n, input logic [47:0] e,
                       input logic [47:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic check_rng(input string n, input int lo, input int hi,
                           input int g);
    checks++;
    if (g < lo || g > hi)
    begin
      $display("unexpected %s expected %0d..%0d seen %0d", n, lo, hi, g);
      num_errors++;
    end
  endtask

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = `RHT_CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? `RHT_CRC_POLY : 8'h00);
    return c;
  endfunction

  task automatic send(input logic [6:0] a, input int n, input logic [7:0] c,
                      output logic ak, output logic ck);
    u_rht_host.bus_start();
    u_rht_host.wr_byte({a, 1'b0}, ak);
    ck = 1'b0;
    if (n > 0)
      u_rht_host.wr_byte(c, ck);
    u_rht_host.bus_stop();
  endtask

  task automatic fetch(input int n, output logic [47:0] q);
    logic [7:0] b;
    logic       ak;
    q = '0;
    u_rht_host.bus_start();
    u_rht_host.wr_byte({7'h40, 1'b1}, ak);
    for (int i = 0; i < n; i++)
    begin
      u_rht_host.rd_byte(i == n - 1, b);
      q = {q[39:0], b};
    end
    u_rht_host.bus_stop();
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 30000 && ready !== 1'b1; i++)
      @(posedge clk);
  endtask

  task automatic pulse(input int n);
    @(posedge clk) rst_pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    rst_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_startup();
    logic ak;
    logic ck;
    int   t0;
    repeat (3) @(posedge clk);
    check("ready", 0, ready);
    check("sda_oe", 0, sda_oe);
    check("sda_out", 0, sda_out);
    nrst <= 1'b1;
    t0 = cyc;
    send(7'h40, 0, 8'h00, ak, ck);
    check("early_ack", 0, ak);
    wait_ready();
    check_rng("startup", PWR - 2, PWR + 4, t_ready - t0);
    $display("test startup done");
  endtask

  task automatic t_addr();
    logic ak;
    logic ck;
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clk) strap <= s[0];
      send({6'h20, s[0]}, 0, 8'h00, ak, ck);
      check("own_ack", 1, ak);
      send({6'h20, ~s[0]}, 0, 8'h00, ak, ck);
      check("other_ack", 0, ak);
    end
    send(7'h00, 0, 8'h00, ak, ck);
    check("soft_ack", 0, ak);
    @(posedge clk) strap <= 1'b0;
    $display("test address done");
  endtask

  task automatic t_conv();
    int         hum [4];
    int         tmp [4];
    int         e;
    logic [1:0] hh;
    logic       ak;
    logic       ck;
    hum = '{`RHT_HUM0_10US, `RHT_HUM1_10US, `RHT_HUM2_10US, `RHT_HUM3_10US};
    tmp = '{`RHT_TMP0_10US, `RHT_TMP1_10US, `RHT_TMP2_10US, `RHT_TMP3_10US};
    for (int k = 0; k < 4; k++)
    begin
      hh = k[1:0];
      e = (hum[k] + tmp[3 - k]) * TICK;
      send(7'h40, 1, {`RHT_CMD_CONV, hh, ~hh, 1'b0}, ak, ck);
      check("conv_ack", 1, ck);
      check("busy", 1, meas_busy);
      for (int i = 0; i < 12000 && meas_busy !== 1'b0; i++)
        @(posedge clk);
      check_rng("conv_time", e - 2, e + 2, t_fall - t_rise);
    end
    @(posedge clk) raw_hum <= ~HUM_A;
    raw_tmp <= ~TMP_A;
    $display("test conversion done");
  endtask

  task automatic t_read();
    logic [47:0] q;
    logic        ak;
    logic        ck;
    send(7'h40, 1, {`RHT_CMD_RD_TRH, 1'b0}, ak, ck);
    fetch(6, q);
    check("trh", {TMP_A, crc8(TMP_A), HUM_A, crc8(HUM_A)}, q);
    send(7'h40, 1, {`RHT_CMD_RD_RH, 1'b0}, ak, ck);
    u_rht_host.half_ns = 1000.0;
    fetch(3, q);
    u_rht_host.half_ns = 62.5;
    check("rh_slow", {HUM_A, crc8(HUM_A)}, q[23:0]);
    check("stable", 0, u_rht_host.unstable);
    $display("test read done");
  endtask

  task automatic t_pin_reset();
    logic ak;
    logic ck;
    int   t0;
    send(7'h40, 1, {`RHT_CMD_HEAT_ON, 1'b0}, ak, ck);
    check("heat_on", 1, heater_en);
    send(7'h40, 1, {`RHT_CMD_HEAT_OFF, 1'b0}, ak, ck);
    check("heat_off", 0, heater_en);
    send(7'h40, 1, {`RHT_CMD_HEAT_ON, 1'b0}, ak, ck);
    pulse(150);
    check("short_rdy", 1, ready);
    check("short_heat", 1, heater_en);
    pulse(240);
    t0 = cyc;
    check("long_rdy", 0, ready);
    check("long_heat", 0, heater_en);
    wait_ready();
    check_rng("restart", PWR - 8, PWR + 4, t_ready - t0);
    $display("test pin reset done");
  endtask

  // Soft reset acts at the stop and restores read select and heater
  task automatic t_soft_reset();
    logic [47:0] q;
    logic        ak;
    logic        ck;
    int          t0;
    send(7'h40, 1, {`RHT_CMD_HEAT_ON, 1'b0}, ak, ck);
    send(7'h40, 1, {`RHT_CMD_RD_RH, 1'b0}, ak, ck);
    send(7'h40, 1, {`RHT_CMD_RESET, 1'b0}, ak, ck);
    t0 = cyc;
    check("rst_ack", 1, ck);
    check("srst_rdy", 0, ready);
    check("srst_heat", 0, heater_en);
    send(7'h40, 0, 8'h00, ak, ck);
    check("srst_early_ack", 0, ak);
    wait_ready();
    check_rng("soft_restart", SRST - 20, SRST + 4, t_ready - t0);
    fetch(6, q);
    check("srst_trh", {TMP_A, crc8(TMP_A), HUM_A, crc8(HUM_A)}, q);
    $display("test soft reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Run control
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #400000;
    num_errors++;
    $display("unexpected watchdog expiry");
    complete_run();
  end

  initial
  begin
    nrst      = 1'b0;
    rst_pin_n = 1'b1;
    strap     = 1'b0;
    raw_hum   = HUM_A;
    raw_tmp   = TMP_A;
    t_startup();
    t_addr();
    t_conv();
    t_read();
    t_pin_reset();
    t_soft_reset();
    complete_run();
  end
endmodule
